// >>> include/tac_bus_if.sv
// register access carrier between serial port and comparator core
`timescale 1ns/10ps
`default_nettype none
interface tac_bus_if;
	logic wr_stb;
	logic [1:0] ptr;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic conv_rd;
	logic ara_req;
	logic ara_won;
	modport link(output wr_stb, ptr, wr_data, conv_rd, ara_won,
		input rd_data, ara_req);
	modport core(input wr_stb, ptr, wr_data, conv_rd, ara_won,
		output rd_data, ara_req);
endinterface
`default_nettype wire

// >>> include/tac_pkg.sv
// constants for the threshold alert comparator
`default_nettype none
package tac_pkg;
	localparam logic [1:0] TAC_PTR_CONV = 2'h0;
	localparam logic [1:0] TAC_PTR_CFG = 2'h1;
	localparam logic [1:0] TAC_PTR_LO = 2'h2;
	localparam logic [1:0] TAC_PTR_HI = 2'h3;
	localparam logic [15:0] TAC_CFG_RST = 16'h8583;
	localparam logic [15:0] TAC_LO_RST = 16'h8000;
	localparam logic [15:0] TAC_HI_RST = 16'h7fff;
	localparam logic [15:0] TAC_CONV_RST = 16'h0000;
	localparam int TAC_STATUS_BIT = 15;
	localparam int TAC_MODE_BIT = 8;
	localparam int TAC_WIN_BIT = 4;
	localparam int TAC_POL_BIT = 3;
	localparam int TAC_LAT_BIT = 2;
	localparam int TAC_QUE_LSB = 0;
	localparam logic [1:0] TAC_QUE_OFF = 2'h3;
	localparam logic [6:0] TAC_ARA_ADDR = 7'h0c;
	localparam logic [3:0] TAC_BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] TAC_RUN_MAX = 3'h4;
	typedef enum logic [2:0] {
		TAC_IDLE, TAC_ADDR, TAC_ACK_A, TAC_RX, TAC_ACK_R, TAC_TX, TAC_TX_ACK
	} tac_st_t;
endpackage
`default_nettype wire

// >>> rtl/tac_serial.sv
// serial register port with alert response arbitration
`timescale 1ns/10ps
`default_nettype none
module tac_serial #(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe,
	tac_bus_if.link bus
);
	import tac_pkg::*;
	logic scl_s1_r, scl_s2_r, scl_s3_r, sda_s1_r, sda_s2_r, sda_s3_r;
	tac_st_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt, msb_r, msb_nxt;
	logic [1:0] ptr_r, ptr_nxt, bidx_r, bidx_nxt;
	logic rw_r, rw_nxt, ara_r, ara_nxt, lsb_r, lsb_nxt, nack_r, nack_nxt;
	logic oe_r, oe_nxt, wr_r, wr_nxt, crd_r, crd_nxt, won_r, won_nxt;
	logic [15:0] wdat_r, wdat_nxt;
	logic start, stop, rise, fall;
	logic [7:0] tx_byte;

	initial begin
		if (DEV_ADDR == TAC_ARA_ADDR)
			$error("device address collides with alert response address");
	end

	assign start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
	assign stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
	assign rise = scl_s2_r & ~scl_s3_r;
	assign fall = ~scl_s2_r & scl_s3_r;
	assign tx_byte = ara_r ? {DEV_ADDR, 1'b0} :
		(lsb_r ? bus.rd_data[7:0] : bus.rd_data[15:8]);

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		msb_nxt = msb_r;
		ptr_nxt = ptr_r;
		bidx_nxt = bidx_r;
		rw_nxt = rw_r;
		ara_nxt = ara_r;
		lsb_nxt = lsb_r;
		nack_nxt = nack_r;
		oe_nxt = oe_r;
		wdat_nxt = wdat_r;
		wr_nxt = 1'b0;
		crd_nxt = 1'b0;
		won_nxt = 1'b0;
		if (stop) begin
			st_nxt = TAC_IDLE;
			oe_nxt = 1'b0;
		end else if (start) begin
			st_nxt = TAC_ADDR;
			cnt_nxt = 4'h0;
			bidx_nxt = 2'h0;
			oe_nxt = 1'b0;
		end else if (rise) begin
			unique case (st_r)
				TAC_ADDR, TAC_RX: begin
					sh_nxt = {sh_r[6:0], sda_s2_r};
					cnt_nxt = cnt_r + 4'h1;
				end
				TAC_TX: begin
					cnt_nxt = cnt_r + 4'h1;
					if (ara_r && !oe_r && !sda_s2_r) begin
						st_nxt = TAC_IDLE;
					end
				end
				TAC_TX_ACK: nack_nxt = sda_s2_r;
				TAC_IDLE, TAC_ACK_A, TAC_ACK_R: begin
				end
			endcase
		end else if (fall) begin
			unique case (st_r)
				TAC_ADDR: begin
					if (cnt_r == TAC_BITS_PER_BYTE) begin
						cnt_nxt = 4'h0;
						rw_nxt = sh_r[0];
						ara_nxt = 1'b0;
						lsb_nxt = 1'b0;
						if (sh_r[7:1] == DEV_ADDR) begin
							st_nxt = TAC_ACK_A;
							oe_nxt = 1'b1;
						end else if (sh_r[7:1] == TAC_ARA_ADDR && sh_r[0] &&
							bus.ara_req) begin
							st_nxt = TAC_ACK_A;
							oe_nxt = 1'b1;
							ara_nxt = 1'b1;
						end else begin
							st_nxt = TAC_IDLE;
						end
					end
				end
				TAC_ACK_A, TAC_ACK_R: begin
					if (rw_r) begin
						st_nxt = TAC_TX;
						sh_nxt = tx_byte;
						oe_nxt = ~tx_byte[7];
					end else begin
						st_nxt = TAC_RX;
						oe_nxt = 1'b0;
					end
				end
				TAC_RX: begin
					if (cnt_r == TAC_BITS_PER_BYTE) begin
						cnt_nxt = 4'h0;
						st_nxt = TAC_ACK_R;
						oe_nxt = 1'b1;
						bidx_nxt = (bidx_r == 2'h2) ? 2'h1 : bidx_r + 2'h1;
						unique case (bidx_r)
							2'h0: ptr_nxt = sh_r[1:0];
							2'h1: msb_nxt = sh_r;
							default: begin
								wdat_nxt = {msb_r, sh_r};
								wr_nxt = 1'b1;
							end
						endcase
					end
				end
				TAC_TX: begin
					if (cnt_r == TAC_BITS_PER_BYTE) begin
						cnt_nxt = 4'h0;
						st_nxt = TAC_TX_ACK;
						oe_nxt = 1'b0;
						crd_nxt = lsb_r && !ara_r && ptr_r == TAC_PTR_CONV;
						won_nxt = ara_r;
						lsb_nxt = ~lsb_r;
					end else begin
						oe_nxt = ~sh_r[6];
						sh_nxt = {sh_r[6:0], 1'b0};
					end
				end
				TAC_TX_ACK: begin
					if (nack_r || ara_r) begin
						st_nxt = TAC_IDLE;
					end else begin
						st_nxt = TAC_TX;
						sh_nxt = tx_byte;
						oe_nxt = ~tx_byte[7];
					end
				end
				TAC_IDLE: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_s3_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_s3_r <= 1'b1;
			st_r <= TAC_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			msb_r <= 8'h00;
			ptr_r <= TAC_PTR_CONV;
			bidx_r <= 2'h0;
			rw_r <= 1'b0;
			ara_r <= 1'b0;
			lsb_r <= 1'b0;
			nack_r <= 1'b0;
			oe_r <= 1'b0;
			wdat_r <= 16'h0000;
			wr_r <= 1'b0;
			crd_r <= 1'b0;
			won_r <= 1'b0;
		end else begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_s3_r <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_s3_r <= sda_s2_r;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			msb_r <= msb_nxt;
			ptr_r <= ptr_nxt;
			bidx_r <= bidx_nxt;
			rw_r <= rw_nxt;
			ara_r <= ara_nxt;
			lsb_r <= lsb_nxt;
			nack_r <= nack_nxt;
			oe_r <= oe_nxt;
			wdat_r <= wdat_nxt;
			wr_r <= wr_nxt;
			crd_r <= crd_nxt;
			won_r <= won_nxt;
		end
	end

	// open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe = oe_r;
	assign bus.wr_stb = wr_r;
	assign bus.ptr = ptr_r;
	assign bus.wr_data = wdat_r;
	assign bus.conv_rd = crd_r;
	assign bus.ara_won = won_r;
endmodule
`default_nettype wire

// >>> rtl/tac_top.sv
// threshold alert comparator with alert/ready pin and serial register port
`timescale 1ns/10ps
`default_nettype none
module tac_top #(
	parameter logic [6:0] DEV_ADDR = 7'h2a,
	parameter int RDY_PULSE_CYCLES = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [15:0] conv_data,
	input wire logic conv_valid,
	input wire logic conv_busy,
	output logic alert_pin_o,
	output logic alert_pin_oe
);
	import tac_pkg::*;
	tac_bus_if bus();
	logic [15:0] cfg_r, cfg_nxt, lo_r, lo_nxt, hi_r, hi_nxt, conv_r, conv_nxt;
	logic [2:0] run_r, run_nxt, need;
	logic alert_r, alert_nxt, pin_r, pin_nxt, pin_oe_r, pin_oe_nxt;
	logic [7:0] pls_r, pls_nxt;
	logic [1:0] que;
	logic win, lat, single, disabled, rdy_mode, gt_hi, lt_lo, beyond, active;
	logic status;

	initial begin
		if (RDY_PULSE_CYCLES < 1 || RDY_PULSE_CYCLES > 255)
			$error("ready pulse length must be 1 to 255 cycles");
	end

	tac_serial #(.DEV_ADDR(DEV_ADDR)) u_serial (
		.clk(clk),
		.sys_rst(sys_rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.bus(bus.link)
	);

	assign status = ~conv_busy;
	assign que = cfg_r[TAC_QUE_LSB +: 2];
	assign win = cfg_r[TAC_WIN_BIT];
	assign lat = cfg_r[TAC_LAT_BIT];
	assign single = cfg_r[TAC_MODE_BIT];
	assign disabled = (que == TAC_QUE_OFF);
	assign rdy_mode = hi_r[15] & ~lo_r[15];
	assign gt_hi = $signed(conv_data) > $signed(hi_r);
	assign lt_lo = $signed(conv_data) < $signed(lo_r);
	assign beyond = win ? (gt_hi | lt_lo) : gt_hi;

	always_comb begin
		unique case (que)
			2'h0: need = 3'h1;
			2'h1: need = 3'h2;
			default: need = TAC_RUN_MAX;
		endcase
	end

	always_comb begin
		bus.rd_data = 16'h0000;
		unique case (bus.ptr)
			TAC_PTR_CONV: bus.rd_data = conv_r;
			TAC_PTR_CFG: bus.rd_data = {status, cfg_r[14:0]};
			TAC_PTR_LO: bus.rd_data = lo_r;
			TAC_PTR_HI: bus.rd_data = hi_r;
		endcase
	end
	assign bus.ara_req = alert_r & ~disabled & ~rdy_mode;

	always_comb begin
		cfg_nxt = cfg_r;
		lo_nxt = lo_r;
		hi_nxt = hi_r;
		conv_nxt = conv_valid ? conv_data : conv_r;
		// result register is read only; status bit is never stored
		if (bus.wr_stb) begin
			unique case (bus.ptr)
				TAC_PTR_CFG: cfg_nxt = {cfg_r[15], bus.wr_data[14:0]};
				TAC_PTR_LO: lo_nxt = bus.wr_data;
				TAC_PTR_HI: hi_nxt = bus.wr_data;
				TAC_PTR_CONV: begin
				end
			endcase
		end
	end

	always_comb begin
		alert_nxt = alert_r;
		run_nxt = run_r;
		if (lat && (bus.conv_rd || bus.ara_won))
			alert_nxt = 1'b0;
		if (disabled) begin
			alert_nxt = 1'b0;
			run_nxt = 3'h0;
		end else if (conv_valid) begin
			if (beyond) begin
				run_nxt = (run_r == TAC_RUN_MAX) ? run_r : run_r + 3'h1;
				// assert after run; set beats clear
				if (run_r + 3'h1 >= need)
					alert_nxt = 1'b1;
			end else begin
				run_nxt = 3'h0;
				if (!lat && (win || lt_lo))
					alert_nxt = 1'b0;
			end
		end
	end

	always_comb begin
		pls_nxt = pls_r;
		if (rdy_mode && !single && conv_valid)
			pls_nxt = RDY_PULSE_CYCLES[7:0];
		else if (pls_r != 8'h00)
			pls_nxt = pls_r - 8'h01;
		if (rdy_mode)
			active = single ? status : (pls_r != 8'h00);
		else
			active = alert_r;
		pin_nxt = cfg_r[TAC_POL_BIT] ? active : ~active;
		pin_oe_nxt = ~disabled;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_r <= TAC_CFG_RST;
			lo_r <= TAC_LO_RST;
			hi_r <= TAC_HI_RST;
			conv_r <= TAC_CONV_RST;
			run_r <= 3'h0;
			alert_r <= 1'b0;
			pls_r <= 8'h00;
			pin_r <= 1'b1;
			pin_oe_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
			conv_r <= conv_nxt;
			run_r <= run_nxt;
			alert_r <= alert_nxt;
			pls_r <= pls_nxt;
			pin_r <= pin_nxt;
			pin_oe_r <= pin_oe_nxt;
		end
	end

	assign alert_pin_o = pin_r;
	assign alert_pin_oe = pin_oe_r;
endmodule
`default_nettype wire

// >>> sim/tac_chk_asserts.sv
// port assertions for the threshold alert comparator
`timescale 1ns/10ps
`default_nettype none
module tac_chk #(
	parameter int RDY_PULSE_CYCLES = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic [15:0] conv_data,
	input wire logic conv_valid,
	input wire logic conv_busy,
	input wire logic alert_pin_o,
	input wire logic alert_pin_oe
);
	localparam int QT = RDY_PULSE_CYCLES + 8;
	logic [5:0] q_cnt_r, q_cnt_nxt;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// cycles since any cause that may move the pin
	always_comb begin
		q_cnt_nxt = q_cnt_r + {5'h0, q_cnt_r != 6'h3f};
		if (conv_valid || conv_busy || !scl_in) begin
			q_cnt_nxt = 6'h0;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q_cnt_r <= 6'h0;
		end else begin
			q_cnt_r <= q_cnt_nxt;
		end
	end
	sequence s_stop;
		scl_in && $past(scl_in) && $rose(sda_in);
	endsequence
	sequence s_calm_conv;
		conv_valid && q_cnt_r > QT;
	endsequence
	oe_reset_a: assert property ($fell(sys_rst) |-> !alert_pin_oe)
		else $error("alert pin driven after reset");
	pin_reset_a: assert property ($fell(sys_rst) |-> alert_pin_o)
		else $error("alert pin active after reset");
	sda_quiet_a: assert property ($fell(sys_rst) |-> !sda_oe [*3])
		else $error("data line pulled too early");
	od_low_a: assert property (sda_oe |-> !sda_o)
		else $error("data line driven high");
	pin_quiet_a: assert property (q_cnt_r > QT |-> $stable(alert_pin_o))
		else $error("alert pin moved without cause");
	oe_quiet_a: assert property ($changed(alert_pin_oe) |-> q_cnt_r < 12)
		else $error("pin enable moved without write");
	pin_late_a: assert property (s_calm_conv |-> $stable(alert_pin_o) [*2])
		else $error("alert pin answered early");
	sda_release_a: assert property (s_stop |=> !sda_oe [*4])
		else $error("data line held after stop");
endmodule
bind tac_top tac_chk #(.RDY_PULSE_CYCLES(RDY_PULSE_CYCLES)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_o(sda_o), .sda_oe(sda_oe), .conv_data(conv_data),
	.conv_valid(conv_valid), .conv_busy(conv_busy),
	.alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe)
);
`default_nettype wire

// >>> sim/tac_host.sv
// serial bus host model, open-drain data, clock idles high
`timescale 1ns/10ps
`default_nettype none
module tac_host (
	input wire logic clk,
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// two-cycle steps give 8-cycle bits, well above the 4-cycle minimum
	task automatic q();
		repeat (2) @(posedge clk);
	endtask
	task automatic start();
		sda_low <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda_low <= 1'b1;
		q();
		scl <= 1'b0;
		q();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_low <= 1'b0;
		q();
		q();
	endtask
	// eight data bits then ack bit, msb first; samples the wire
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			sda_low <= !d[i];
			q();
			scl <= 1'b1;
			q();
			r[i] = sda;
			q();
			scl <= 1'b0;
			q();
		end
	endtask
endmodule
`default_nettype wire

// >>> sim/test_threshold_alert_comparator.sv
// self-checking bench for the threshold alert comparator
`timescale 1ns/10ps
`default_nettype none
module test_threshold_alert_comparator;
	import tac_pkg::*;
	localparam int RDY = 8;
	localparam logic [6:0] ADR = 7'h2a;
	logic clk, sys_rst, scl, sda_low, sda, sda_o, sda_oe, cv, busy, pin, oe;
	logic al;
	logic [15:0] cd, cfg, rv;
	logic [8:0] r;
	int failures = 0;
	int n_tests = 0;
	int run, lo, hi;
	// pull-up on the data line
	assign sda = !(sda_low || sda_oe);
	tac_top #(.DEV_ADDR(ADR), .RDY_PULSE_CYCLES(RDY)) uut (.clk(clk),
		.sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .conv_data(cd), .conv_valid(cv), .conv_busy(busy),
		.alert_pin_o(pin), .alert_pin_oe(oe));
	tac_host host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wb(input logic [7:0] b);
		host.xfer({b, 1'b1}, r);
		chk(r[0], 1'b0);
	endtask
	task automatic wr(input logic [1:0] p, input logic [15:0] v);
		host.start();
		wb({ADR, 1'b0});
		wb({6'h0, p});
		wb(v[15:8]);
		wb(v[7:0]);
		host.stop();
	endtask
	task automatic rd(input logic [1:0] p, output logic [15:0] v);
		// pointer only: a data pair here would overwrite the register
		host.start();
		wb({ADR, 1'b0});
		wb({6'h0, p});
		host.stop();
		host.start();
		wb({ADR, 1'b1});
		host.xfer(9'h1fe, r);
		v[15:8] = r[8:1];
		host.xfer(9'h1ff, r);
		v[7:0] = r[8:1];
		host.stop();
	endtask
	// reference model updated per result, then pin compared
	task automatic conv(input logic [15:0] d, input logic c);
		int x, n;
		logic b;
		x = int'($signed(d));
		n = cfg[1] ? 4 : int'(cfg[0]) + 1;
		b = x > hi || (cfg[4] && x < lo);
		run = b ? run + 1 : 0;
		if (run >= n) begin
			al = 1'b1;
		end else if (!cfg[2] && (cfg[4] ? !b : x < lo)) begin
			al = 1'b0;
		end
		cd <= d;
		cv <= 1'b1;
		@(posedge clk);
		cv <= 1'b0;
		repeat (3) @(posedge clk);
		if (c) begin
			chk({oe, pin}, {1'b1, al ^ !cfg[3]});
		end
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		end_sim();
	end
	initial begin
		sys_rst = 1'b1;
		cv = 1'b0;
		cd = 16'h0;
		busy = 1'b0;
		lo = -100;
		hi = 100;
		void'($urandom(12898));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(oe, 1'b0);
		rd(TAC_PTR_LO, rv);
		chk(rv, 16'h8000);
		rd(TAC_PTR_HI, rv);
		chk(rv, 16'h7fff);
		rd(TAC_PTR_CFG, rv);
		chk(rv, TAC_CFG_RST);
		// gain untouched, high kept above low
		wr(TAC_PTR_LO, 16'hff9c);
		wr(TAC_PTR_HI, 16'h0064);
		for (int k = 0; k < 12; k++) begin
			cfg = 16'h8580 | 16'((k / 3 % 2) * 16 + k / 6 * 8 + k % 3);
			wr(TAC_PTR_CFG, cfg);
			rd(TAC_PTR_CFG, rv);
			chk(rv, cfg);
			run = 0;
			al = 1'b0;
			conv(16'hff6a, 1'b0);
			conv(16'h0000, 1'b0);
			for (int j = 0; j < 24; j++) begin
				conv(16'($urandom_range(400) - 200), 1'b1);
			end
		end
		cfg = 16'h8584;
		wr(TAC_PTR_CFG, cfg);
		conv(16'h00c8, 1'b1);
		conv(16'hff00, 1'b1);
		rd(TAC_PTR_CONV, rv);
		chk(rv, 16'hff00);
		chk(pin, 1'b1);
		conv(16'h00c8, 1'b1);
		// lower address on the bus wins; alert stays latched
		host.start();
		wb(8'h19);
		host.xfer({7'h01, 1'b0, 1'b1}, r);
		chk(r[8:1], 8'h02);
		host.stop();
		chk(pin, 1'b0);
		// alert response: device answers with its own address
		host.start();
		wb(8'h19);
		host.xfer(9'h1ff, r);
		chk(r[8:1], {ADR, 1'b0});
		host.stop();
		chk(pin, 1'b1);
		wr(TAC_PTR_HI, 16'h8000);
		wr(TAC_PTR_LO, 16'h0000);
		wr(TAC_PTR_CFG, 16'h8580);
		busy <= 1'b1;
		rd(TAC_PTR_CFG, rv);
		chk(rv, 16'h0580);
		// idle status counts as asserted, so active low shows 0 when idle
		chk({oe, pin}, 16'h3);
		busy <= 1'b0;
		repeat (4) @(posedge clk);
		chk({oe, pin}, 16'h2);
		wr(TAC_PTR_CFG, 16'h8480);
		repeat (20) @(posedge clk);
		conv(16'h1234, 1'b0);
		chk(pin, 1'b0);
		repeat (RDY - 2) @(posedge clk);
		chk(pin, 1'b0);
		@(posedge clk);
		chk(pin, 1'b1);
		wr(TAC_PTR_CFG, 16'h8483);
		chk(oe, 1'b0);
		repeat (20) @(posedge clk);
		end_sim();
	end
endmodule
`default_nettype wire
